// [inc/spi_master_pkg.sv]
/*
 * constants for the serial master unit: register map, field layout,
 * reset values, clock-rate codes and engine states.
 * assumes a 10 MHz system clock and a byte-wide memory port.
 */
`default_nettype none

package spi_master_pkg;
    // ----------------------------------------------------------------
    // clock and rates
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 10000000;
    localparam int RATE_BASE_BPS = 125000;
    localparam int RATE_STEPS = 7;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_FREQ = 12'h524;
    localparam logic [11:0] OFS_RX_PTR = 12'h534;
    localparam logic [11:0] OFS_RX_LIM = 12'h538;
    localparam logic [11:0] OFS_RX_DONE = 12'h53c;
    localparam logic [11:0] OFS_RX_CHAIN = 12'h540;
    localparam logic [11:0] OFS_TX_PTR = 12'h544;
    localparam logic [11:0] OFS_TX_LIM = 12'h548;
    localparam logic [11:0] OFS_TX_DONE = 12'h54c;
    localparam logic [11:0] OFS_TX_CHAIN = 12'h550;
    localparam logic [11:0] OFS_CONFIG = 12'h554;
    localparam logic [11:0] OFS_FILL = 12'h5c0;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int LIM_W = 14;
    localparam int CHAIN_W = 2;
    localparam logic [1:0] CHAIN_NONE = 2'h0;
    localparam logic [1:0] CHAIN_CONSECUTIVE_BUFFERS = 2'h1;
    localparam int CFG_LOW_BIT_LEADING = 0;
    localparam int CFG_CPHA = 1;
    localparam int CFG_CPOL = 2;
    localparam int FREQ_LSB = 25;
    localparam logic [31:0] FREQ_RESET = 32'h04000000;
    localparam logic [31:0] ZERO_RESET = 32'h00000000;
    localparam int HALF_W = 8;
    localparam int EDGES_PER_BYTE = 16;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_REQ = 3'h2,
        ST_LOAD = 3'h3,
        ST_SHIFT = 3'h4,
        ST_FINISH = 3'h5
    } engine_state_e;

    // half serial clock period in system cycles, rounded down, at least 1
    function automatic logic [7:0] half_cycles(input logic [31:0] code);
        int h;
        h = CLK_HZ / (2 * RATE_BASE_BPS);
        for (int k = 0; k < RATE_STEPS; k++)
        begin
            if (code[FREQ_LSB + k])
                h = CLK_HZ / (2 * (RATE_BASE_BPS << k));
        end
        if (h < 1)
            h = 1;
        return h[7:0];
    endfunction : half_cycles
endpackage : spi_master_pkg

`default_nettype wire

// [core/pin_sync.sv]
/*
 * two-flop synchroniser for one level from outside the clock domain.
 * assumes the input is a plain level with no timing relation to i_clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_sync
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_r;

    // first flop feeds only the second one
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            meta_r <= 1'b0;
            o_sync <= 1'b0;
        end
        else
        begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule : pin_sync

`default_nettype wire

// [core/byte_shifter.sv]
/*
 * one-byte serial shifter: builds the serial clock from a half-period
 * count and shifts one byte out and one byte in per go pulse.
 * assumes i_miso is already synchronised and settings hold during a byte.
 */
`timescale 1ns/10ps
`default_nettype none

module byte_shifter
    import spi_master_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_go,
    input wire logic [7:0] i_byte,
    input wire logic i_cpol,
    input wire logic i_cpha,
    input wire logic i_low_first,
    input wire logic [7:0] i_half,
    input wire logic i_miso,
    output logic o_sck,
    output logic o_mosi,
    output logic o_done,
    output logic [7:0] o_rx_byte
);
    logic busy_r;
    logic [7:0] hcnt_r;
    logic [4:0] ecnt_r;
    logic [7:0] tx_r;
    logic edge_now;
    logic sample_now;
    logic last_edge;
    logic out_bit;
    logic [7:0] tx_adv;

    assign edge_now = busy_r && (hcnt_r == i_half - 8'h01);
    // even edges lead; phase 0 samples on leading, phase 1 on trailing
    assign sample_now = ~ecnt_r[0] ^ i_cpha;
    assign last_edge = (ecnt_r == 5'(EDGES_PER_BYTE - 1));
    assign out_bit = i_low_first ? tx_r[0] : tx_r[7];
    assign tx_adv = i_low_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};

    // ----------------------------------------------------------------
    // clock generation
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            busy_r <= 1'b0;
            hcnt_r <= 8'h00;
            ecnt_r <= 5'h00;
            o_sck <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= edge_now && last_edge;
            if (i_go)
            begin
                busy_r <= 1'b1;
                hcnt_r <= 8'h00;
                ecnt_r <= 5'h00;
            end
            else if (edge_now)
            begin
                hcnt_r <= 8'h00;
                ecnt_r <= ecnt_r + 5'h01;
                busy_r <= !last_edge;
            end
            else if (busy_r)
                hcnt_r <= hcnt_r + 8'h01;
            // idle level follows polarity between bytes
            if (!busy_r)
                o_sck <= i_cpol;
            else if (edge_now)
                o_sck <= ~o_sck;
        end
    end

    // ----------------------------------------------------------------
    // data out and in
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            tx_r <= 8'h00;
            o_mosi <= 1'b0;
            o_rx_byte <= 8'h00;
        end
        else if (i_go)
        begin
            // phase 0 must present the first bit before the leading edge
            if (!i_cpha)
            begin
                o_mosi <= i_low_first ? i_byte[0] : i_byte[7];
                tx_r <= i_low_first ? {1'b0, i_byte[7:1]}
                                    : {i_byte[6:0], 1'b0};
            end
            else
                tx_r <= i_byte;
        end
        else if (edge_now)
        begin
            if (sample_now)
                o_rx_byte <= i_low_first ? {i_miso, o_rx_byte[7:1]}
                                         : {o_rx_byte[6:0], i_miso};
            else if (!(last_edge && !i_cpha))
            begin
                o_mosi <= out_bit;
                tx_r <= tx_adv;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    idle_clock_level_a: assert property
        (!busy_r && !i_go ##1 !busy_r |-> o_sck == $past(i_cpol))
        else $error("serial clock not at idle level");
    first_bit_out_a: assert property
        (i_go && !i_cpha && !i_low_first |=> o_mosi == $past(i_byte[7]))
        else $error("high bit not leading");
    // at a half period of ten cycles the sixteenth edge lands 160 later
    byte_edges_a: assert property
        (i_go && i_half == 8'h0a |-> ##160 busy_r
         ##1 (o_done && !busy_r))
        else $error("byte did not take sixteen edges");
endmodule : byte_shifter

`default_nettype wire

// [core/spi_master_dma_buffer_config.sv]
/*
 * serial master unit: register file, byte engine with memory access,
 * limits, transferred-byte counters, chaining and fill character.
 * assumes a byte-wide memory answering a read in the cycle after o_mem_rd
 * and a single-cycle register port; miso arrives asynchronously.
 */
`timescale 1ns/10ps
`default_nettype none

module spi_master_dma_buffer_config
    import spi_master_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_start,
    output logic o_busy,
    output logic o_end,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [31:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    input wire logic [7:0] i_mem_rdata,
    output logic o_sck,
    output logic o_mosi,
    input wire logic i_miso
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [31:0] freq_r;
    logic [31:0] rx_ptr_r;
    logic [LIM_W-1:0] rx_lim_r;
    logic [LIM_W-1:0] rx_done_r;
    logic [CHAIN_W-1:0] rx_chain_r;
    logic [31:0] tx_ptr_r;
    logic [LIM_W-1:0] tx_lim_r;
    logic [LIM_W-1:0] tx_done_r;
    logic [CHAIN_W-1:0] tx_chain_r;
    logic [2:0] cfg_r;
    logic [7:0] fill_r;
    logic [31:0] rdata_nxt;

    // engine
    engine_state_e state_r;
    logic [LIM_W-1:0] idx_r;
    logic [LIM_W-1:0] total_r;
    logic [LIM_W-1:0] rx_cnt_r;
    logic [LIM_W-1:0] tx_cnt_r;
    logic [7:0] byte_r;
    logic go_r;
    logic [7:0] half_r;
    logic miso_s;
    logic shift_done;
    logic [7:0] rx_byte;
    logic [LIM_W-1:0] longer_lim;
    logic idle;

    assign idle = (state_r == ST_IDLE);
    // transaction length is the larger of the two limits
    assign longer_lim = (rx_lim_r > tx_lim_r) ? rx_lim_r : tx_lim_r;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // writes that land while busy still store; the engine snapshots
    // only the length, so changing limits mid-transfer is unsafe
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            freq_r <= FREQ_RESET;
            rx_lim_r <= ZERO_RESET[LIM_W-1:0];
            tx_lim_r <= ZERO_RESET[LIM_W-1:0];
            rx_chain_r <= ZERO_RESET[CHAIN_W-1:0];
            tx_chain_r <= ZERO_RESET[CHAIN_W-1:0];
            cfg_r <= ZERO_RESET[2:0];
            fill_r <= ZERO_RESET[7:0];
        end
        else if (i_wr)
        begin
            unique case (i_addr)
                OFS_FREQ: freq_r <= i_wdata;
                OFS_RX_LIM: rx_lim_r <= i_wdata[LIM_W-1:0];
                OFS_TX_LIM: tx_lim_r <= i_wdata[LIM_W-1:0];
                OFS_RX_CHAIN: rx_chain_r <= i_wdata[CHAIN_W-1:0];
                OFS_TX_CHAIN: tx_chain_r <= i_wdata[CHAIN_W-1:0];
                OFS_CONFIG: cfg_r <= i_wdata[2:0];
                OFS_FILL: fill_r <= i_wdata[7:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // buffer pointers: software writes, chaining advances at the end
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            rx_ptr_r <= ZERO_RESET;
            tx_ptr_r <= ZERO_RESET;
        end
        else if (state_r == ST_FINISH)
        begin
            // next transaction uses the buffer right after this one
            if (rx_chain_r == CHAIN_CONSECUTIVE_BUFFERS)
                rx_ptr_r <= rx_ptr_r + 32'(rx_lim_r);
            if (tx_chain_r == CHAIN_CONSECUTIVE_BUFFERS)
                tx_ptr_r <= tx_ptr_r + 32'(tx_lim_r);
        end
        else if (i_wr && i_addr == OFS_RX_PTR)
            rx_ptr_r <= i_wdata;
        else if (i_wr && i_addr == OFS_TX_PTR)
            tx_ptr_r <= i_wdata;
    end

    // ----------------------------------------------------------------
    // register reads, data one cycle after the strobe
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = ZERO_RESET;
        unique case (i_addr)
            OFS_FREQ: rdata_nxt = freq_r;
            OFS_RX_PTR: rdata_nxt = rx_ptr_r;
            OFS_RX_LIM: rdata_nxt = 32'(rx_lim_r);
            OFS_RX_DONE: rdata_nxt = 32'(rx_done_r);
            OFS_RX_CHAIN: rdata_nxt = 32'(rx_chain_r);
            OFS_TX_PTR: rdata_nxt = tx_ptr_r;
            OFS_TX_LIM: rdata_nxt = 32'(tx_lim_r);
            OFS_TX_DONE: rdata_nxt = 32'(tx_done_r);
            OFS_TX_CHAIN: rdata_nxt = 32'(tx_chain_r);
            OFS_CONFIG: rdata_nxt = 32'(cfg_r);
            OFS_FILL: rdata_nxt = 32'(fill_r);
            default: rdata_nxt = ZERO_RESET;
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            o_rdata <= ZERO_RESET;
        else if (i_rd)
            o_rdata <= rdata_nxt;
        else
            o_rdata <= ZERO_RESET;
    end

    // ----------------------------------------------------------------
    // rate selection
    // ----------------------------------------------------------------
    // registered so the divider sees a stable count; 4 and 8 Mbps
    // saturate at one cycle per half period on a 10 MHz clock
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            half_r <= half_cycles(FREQ_RESET);
        else
            half_r <= half_cycles(freq_r);
    end

    // ----------------------------------------------------------------
    // byte engine
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            state_r <= ST_IDLE;
            idx_r <= '0;
            total_r <= '0;
            byte_r <= 8'h00;
            go_r <= 1'b0;
        end
        else
        begin
            go_r <= 1'b0;
            unique case (state_r)
                ST_IDLE:
                begin
                    if (i_start)
                    begin
                        idx_r <= '0;
                        total_r <= longer_lim;
                        state_r <= (longer_lim == '0) ? ST_FINISH
                                                      : ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    if (idx_r < tx_lim_r)
                        state_r <= ST_REQ;
                    else
                    begin
                        // transmit buffer exhausted
                        byte_r <= fill_r;
                        go_r <= 1'b1;
                        state_r <= ST_SHIFT;
                    end
                end
                ST_REQ: state_r <= ST_LOAD;
                ST_LOAD:
                begin
                    byte_r <= i_mem_rdata;
                    go_r <= 1'b1;
                    state_r <= ST_SHIFT;
                end
                ST_SHIFT:
                begin
                    if (shift_done)
                    begin
                        idx_r <= idx_r + 14'h0001;
                        state_r <= (idx_r + 14'h0001 == total_r) ? ST_FINISH
                                                                 : ST_FETCH;
                    end
                end
                ST_FINISH: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // memory port
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            o_mem_addr <= ZERO_RESET;
            o_mem_wdata <= 8'h00;
        end
        else
        begin
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            if (state_r == ST_FETCH && idx_r < tx_lim_r)
            begin
                o_mem_rd <= 1'b1;
                o_mem_addr <= tx_ptr_r + 32'(idx_r);
            end
            else if (state_r == ST_SHIFT && shift_done && idx_r < rx_lim_r)
            begin
                // bytes past the receive limit never reach memory
                o_mem_wr <= 1'b1;
                o_mem_addr <= rx_ptr_r + 32'(idx_r);
                o_mem_wdata <= rx_byte;
            end
        end
    end

    // ----------------------------------------------------------------
    // transferred-byte counters
    // ----------------------------------------------------------------
    // running counts stay hidden; the readable ones change only at the end
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            rx_cnt_r <= '0;
            tx_cnt_r <= '0;
            rx_done_r <= '0;
            tx_done_r <= '0;
        end
        else if (idle && i_start)
        begin
            rx_cnt_r <= '0;
            tx_cnt_r <= '0;
        end
        else if (state_r == ST_FINISH)
        begin
            rx_done_r <= rx_cnt_r;
            tx_done_r <= tx_cnt_r;
        end
        else
        begin
            if (state_r == ST_SHIFT && shift_done && idx_r < rx_lim_r)
                rx_cnt_r <= rx_cnt_r + 14'h0001;
            if (state_r == ST_LOAD)
                tx_cnt_r <= tx_cnt_r + 14'h0001;
        end
    end

    // status outputs
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_busy <= 1'b0;
            o_end <= 1'b0;
        end
        else
        begin
            o_busy <= !(state_r == ST_IDLE || state_r == ST_FINISH);
            o_end <= (state_r == ST_FINISH);
        end
    end

    // ----------------------------------------------------------------
    // serial side
    // ----------------------------------------------------------------
    pin_sync u_miso_sync
    (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_async(i_miso),
        .o_sync(miso_s)
    );

    byte_shifter u_shifter
    (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_go(go_r),
        .i_byte(byte_r),
        .i_cpol(cfg_r[CFG_CPOL]),
        .i_cpha(cfg_r[CFG_CPHA]),
        .i_low_first(cfg_r[CFG_LOW_BIT_LEADING]),
        .i_half(half_r),
        .i_miso(miso_s),
        .o_sck(o_sck),
        .o_mosi(o_mosi),
        .o_done(shift_done),
        .o_rx_byte(rx_byte)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    rx_limit_store_a: assert property
        (i_wr && i_addr == OFS_RX_LIM
         |=> rx_lim_r == $past(i_wdata[LIM_W-1:0]))
        else $error("receive limit not stored");
    tx_limit_store_a: assert property
        (i_wr && i_addr == OFS_TX_LIM
         |=> tx_lim_r == $past(i_wdata[LIM_W-1:0]))
        else $error("transmit limit not stored");
    done_read_a: assert property
        (i_rd && i_addr == OFS_RX_DONE |=> o_rdata == 32'($past(rx_done_r)))
        else $error("receive count read wrong");
    chain_advance_a: assert property
        (state_r == ST_FINISH && tx_chain_r == CHAIN_CONSECUTIVE_BUFFERS
         |=> tx_ptr_r == $past(tx_ptr_r) + 32'($past(tx_lim_r)))
        else $error("transmit pointer did not advance");
    fill_used_a: assert property
        (state_r == ST_FETCH && idx_r >= tx_lim_r
         |=> go_r && byte_r == $past(fill_r))
        else $error("fill character not sent");
    rate_half_a: assert property
        (freq_r == 32'h02000000 [*2] |-> half_r == 8'h28)
        else $error("slowest rate half period wrong");
    rx_drop_a: assert property
        (o_mem_wr |-> o_mem_addr - rx_ptr_r < 32'(rx_lim_r))
        else $error("receive write beyond limit");
    count_bound_a: assert property
        (o_end |-> rx_done_r <= rx_lim_r && tx_done_r <= tx_lim_r)
        else $error("counter over its limit");
    end_follows_a: assert property
        (idle && i_start && longer_lim == '0 |=> ##1 o_end)
        else $error("empty transaction did not end");

    end_seen_c: cover property (o_end && rx_done_r != '0);
    chain_seen_c: cover property
        (state_r == ST_FINISH && rx_chain_r == CHAIN_CONSECUTIVE_BUFFERS);
    fill_seen_c: cover property (state_r == ST_FETCH && idx_r >= tx_lim_r);
    low_first_c: cover property (go_r && cfg_r[CFG_LOW_BIT_LEADING]);
endmodule : spi_master_dma_buffer_config

`default_nettype wire

// [verification/spi_slave_model.sv]
/*
 * serial slave model: samples mosi and returns a fixed byte on miso.
 * assumes frame settings hold while i_busy is high.
 */
`timescale 1ns/10ps
`default_nettype none

module spi_slave_model
(
    input wire logic i_sck,
    input wire logic i_busy,
    input wire logic i_mosi,
    input wire logic [2:0] i_cfg,
    input wire logic [7:0] i_pat,
    output logic o_miso
);
    int c = 0;
    int b;
    int k;
    logic [7:0] got [0:63];
    // edges are counted only in a frame: idle polarity changes are no edge
    always @(posedge i_busy)
        c = 0;
    always @(i_sck)
    begin
        b = (c % 16) / 2;
        if (i_busy && ((i_sck != i_cfg[2]) != i_cfg[1]))
            got[(c / 16) % 64][i_cfg[0] ? b : 7 - b] = i_mosi;
        if (i_busy)
            c = c + 1;
    end
    // phase 1 moves the bit on the leading edge, phase 0 on trailing
    always @*
        k = (((c % 16) + (i_cfg[1] ? 15 : 0)) / 2) % 8;
    assign o_miso = i_pat[i_cfg[0] ? k : 7 - k];
endmodule : spi_slave_model

`default_nettype wire

// [verification/spi_master_dma_buffer_config_bench.sv]
/*
 * bench for the serial master unit: register checks, then nine frames
 * against a slave model and a byte memory. assumes spi_master_pkg.
 */
`timescale 1ns/10ps
`default_nettype none

module spi_master_dma_buffer_config_bench
    import spi_master_pkg::*;
;
    logic i_clk_sys = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_start = 0;
    logic [11:0] i_addr = 0;
    logic [31:0] i_wdata = 0, o_rdata, o_mem_addr, seed = 32'h374688fc;
    logic [7:0] i_mem_rdata = 0, o_mem_wdata;
    logic o_busy, o_end, o_mem_rd, o_mem_wr, o_sck, o_mosi, miso;
    logic [2:0] cfg = 0;
    int mismatches = 0, total_checks = 0, nwr = 0;

    spi_master_dma_buffer_config i_spi_master_dma_buffer_config (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_start(i_start), .o_busy(o_busy), .o_end(o_end),
        .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
        .o_sck(o_sck), .o_mosi(o_mosi), .i_miso(miso));
    spi_slave_model i_spi_slave_model (.i_sck(o_sck), .i_busy(o_busy),
        .i_mosi(o_mosi), .i_cfg(cfg), .i_pat(8'hd2), .o_miso(miso));

    initial
    begin
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("wrong value t=%0t seen %h want %h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_wr <= 1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 0;
        @(posedge i_clk_sys);
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        i_rd <= 1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 0;
        #1 d = o_rdata;
        @(posedge i_clk_sys);
    endtask : rd

    // memory answers a read one cycle later; writes land in order
    always @(posedge i_clk_sys)
    begin
        if (o_mem_rd)
            i_mem_rdata <= o_mem_addr[7:0] ^ 8'h5a;
        if (o_mem_wr)
        begin
            chk(32'(o_mem_wdata), 32'hd2);
            chk(o_mem_addr, 32'(nwr));
            nwr++;
        end
    end

    task automatic run(input int m);
        int rl, tl, n, ch;
        logic [31:0] tp, f, d;
        // the last run has both limits at zero: an empty transaction
        rl = m > 7 ? 0 : rnd() % 4;
        tl = m > 7 ? 0 : rnd() % 4;
        tp = rnd();
        f = rnd() & 32'hff;
        ch = (m >> 1) & 1;
        cfg <= 3'(m);
        wr(OFS_RX_LIM, 32'(rl));
        wr(OFS_TX_LIM, 32'(tl));
        wr(OFS_TX_PTR, tp);
        wr(OFS_FILL, f);
        wr(OFS_TX_CHAIN, 32'(ch));
        wr(OFS_CONFIG, 32'(m));
        wr(OFS_FREQ, m[2] ? 32'h08000000
                          : (m[0] ? 32'h02000000 : FREQ_RESET));
        nwr = 0;
        i_start <= 1;
        @(posedge i_clk_sys);
        i_start <= 0;
        @(posedge i_clk_sys) #1;
        chk(32'(o_busy), 32'(rl + tl > 0));
        for (n = 0; n < 8000 && o_end !== 1'b1; n++)
            @(posedge i_clk_sys) #1;
        chk(32'(o_end), 32'h1);
        chk(32'(nwr), 32'(rl));
        for (n = 0; n < (rl > tl ? rl : tl); n++)
            chk(32'(i_spi_slave_model.got[n]),
                n < tl ? 32'(8'(tp[7:0] + 8'(n)) ^ 8'h5a) : f);
        rd(OFS_RX_DONE, d);
        chk(d, 32'(rl));
        rd(OFS_TX_DONE, d);
        chk(d, 32'(tl));
        rd(OFS_TX_PTR, d);
        chk(d, tp + (ch ? 32'(tl) : 0));
        $display("test frame mode %0d done", m);
    endtask : run

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // watchdog: 60000 cycles, well above the at most about 8000 that the frames need
    initial
    begin
        #6000000;
        mismatches++;
        test_done();
    end

    initial
    begin
        logic [31:0] d;
        repeat (8) @(posedge i_clk_sys);
        i_reset <= 0;
        @(posedge i_clk_sys);
        rd(OFS_RX_LIM, d);
        chk(d, ZERO_RESET);
        rd(OFS_TX_LIM, d);
        chk(d, ZERO_RESET);
        rd(OFS_RX_CHAIN, d);
        chk(d, ZERO_RESET);
        rd(OFS_FILL, d);
        chk(d, ZERO_RESET);
        rd(OFS_FREQ, d);
        chk(d, FREQ_RESET);
        wr(OFS_RX_LIM, 32'hffffffff);
        rd(OFS_RX_LIM, d);
        chk(d, 32'h3fff);
        wr(OFS_TX_LIM, 32'hffffffff);
        rd(OFS_TX_LIM, d);
        chk(d, 32'h3fff);
        wr(OFS_RX_DONE, 32'h5);
        rd(OFS_RX_DONE, d);
        chk(d, ZERO_RESET);
        rd(12'h000, d);
        chk(d, ZERO_RESET);
        $display("test registers done");
        for (int m = 0; m < 9; m++)
            run(m);
        test_done();
    end
endmodule : spi_master_dma_buffer_config_bench

`default_nettype wire
